// ---- design/osd_geom_pkg.sv ----
// Purpose: Shared constants and types for the OSD text area geometry registers.
// Assumes: Byte-wide registers at their printed byte addresses on a plain port.
// Notes: All field positions, offsets and limits used by the logic live here.

package osd_geom_pkg;

   // ----------------------------------------------------------------
   // Bus widths and register count
   // ----------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int NUM_REGS = 5;

   // ----------------------------------------------------------------
   // Register addresses and storage indices
   // ----------------------------------------------------------------
   localparam logic [15:0] ADDR_TEXT_VERTICAL_POSITION = 16'h87F1;
   localparam logic [15:0] ADDR_TEXT_HORIZONTAL_POSITION = 16'h87F2;
   localparam logic [15:0] ADDR_FRINGE_CONTROL = 16'h87F3;
   localparam logic [15:0] ADDR_TEXT_AREA_END = 16'h87F4;
   localparam logic [15:0] ADDR_SOFT_SCROLL_AREA_CONTROL = 16'h87F5;
   localparam int IDX_TVP = 0;
   localparam int IDX_THP = 1;
   localparam int IDX_FRC = 2;
   localparam int IDX_TAE = 3;
   localparam int IDX_SSA = 4;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] RDATA_IDLE = 8'h00;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int VSYNC_INVERT_BIT = 7;
   localparam int HSYNC_INVERT_BIT = 6;
   localparam int VOFS_MSB = 5;
   localparam int VOFS_LSB = 0;
   localparam int QOFS_MSB = 7;
   localparam int QOFS_LSB = 6;
   localparam int LEFT_MSB = 5;
   localparam int LEFT_LSB = 0;
   localparam int FCOL_MSB = 7;
   localparam int FCOL_LSB = 4;
   localparam int FN_BIT = 3;
   localparam int FE_BIT = 2;
   localparam int FS_BIT = 1;
   localparam int FW_BIT = 0;
   localparam int RIGHT_MSB = 5;
   localparam int RIGHT_LSB = 0;
   localparam int SH_MSB = 7;
   localparam int SH_LSB = 4;
   localparam int ST_MSB = 3;
   localparam int ST_LSB = 0;

   // ----------------------------------------------------------------
   // Geometry limits
   // ----------------------------------------------------------------
   localparam logic [6:0] END_CODE_BIAS = 7'h01;
   localparam logic [6:0] MAX_WIDTH_CHARS = 7'h30;
   localparam logic [5:0] MIN_SAFE_START = 6'h04;
   localparam logic [5:0] LINE_CNT_ZERO = 6'h00;
   localparam logic [5:0] LINE_CNT_STEP = 6'h01;

   // ----------------------------------------------------------------
   // Vertical text area tracking states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      V_WAIT = 3'b001,
      V_COUNT = 3'b010,
      V_TEXT = 3'b100
   } vert_state_e;

endpackage

// ---- design/osd_text_area_geometry_regs.sv ----
// Purpose: Geometry, sync polarity, fringe and soft scroll registers of the OSD unit.
// Assumes: Sync inputs and the horizontal quarter position are synchronous to i_clk.
// Notes: All state freezes while i_ce is low; read data stands one cycle after the strobe.
//
// Strobed register access was left to the implementer.

`timescale 1ns/100ps

// How it works
// RULE1: vertical sync invert bit set flips the incoming vertical sync.
// RULE2: horizontal sync invert bit set flips the incoming horizontal sync.
// RULE3: text top waits the programmed 0 to 63 scan lines after vsync.
// RULE4: two fine bits move the area right by 0 to 3 quarters.
// RULE5: six start bits place the left edge 0 to 63 characters in.
// RULE6: four colour bits pick one of sixteen fringe colours.
// RULE7: north, east, south and west bits each enable fringing that way.
// RULE8: end field sets the right edge; width is end minus start.
// RULE9: top two bits of the end register have no function.
// RULE10: four height bits give the visible scroll area row count.
// RULE11: four position bits give the top row of the scroll area.
// RULE12: software keeps start codes 0 to 3 out of the start field.
// RULE13: end code is characters minus one; valid widths are 0 to 48.
// RULE14: fine quarter offset also moves the end position.
// RULE15: every register reads back exactly what was last written.
// RULE16: each register is one byte, written whole at its own address.
module osd_text_area_geometry_regs (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_vsync,
   input wire logic i_hsync,
   input wire logic [8:0] i_hpos_quarters,
   output logic [7:0] o_rdata,
   output logic o_vsync,
   output logic o_hsync,
   output logic o_text_rows_active,
   output logic o_text_top,
   output logic o_in_text_area,
   output logic [7:0] o_text_start_quarters,
   output logic [8:0] o_text_end_quarters,
   output logic [6:0] o_text_width_chars,
   output logic o_width_valid,
   output logic o_start_code_bad,
   output logic [3:0] o_fringe_colour,
   output logic o_fringe_north,
   output logic o_fringe_east,
   output logic o_fringe_south,
   output logic o_fringe_west,
   output logic [3:0] o_scroll_window_height,
   output logic [3:0] o_scroll_window_top_row
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------

   // One select line per register, in storage index order.
   wire logic [osd_geom_pkg::NUM_REGS-1:0] sel;
   assign sel[osd_geom_pkg::IDX_TVP] = (i_addr == osd_geom_pkg::ADDR_TEXT_VERTICAL_POSITION);
   assign sel[osd_geom_pkg::IDX_THP] = (i_addr == osd_geom_pkg::ADDR_TEXT_HORIZONTAL_POSITION);
   assign sel[osd_geom_pkg::IDX_FRC] = (i_addr == osd_geom_pkg::ADDR_FRINGE_CONTROL);
   assign sel[osd_geom_pkg::IDX_TAE] = (i_addr == osd_geom_pkg::ADDR_TEXT_AREA_END);
   assign sel[osd_geom_pkg::IDX_SSA] = (i_addr == osd_geom_pkg::ADDR_SOFT_SCROLL_AREA_CONTROL);

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------

   logic [7:0] regs_q [osd_geom_pkg::NUM_REGS];

   // Each register takes a whole byte on a write strobe at its address.
   // Reserved bits are stored as written so that read-back stays exact.
   genvar gi;
   generate
      for (gi = 0; gi < osd_geom_pkg::NUM_REGS; gi++) begin : g_reg
         // RULE16: whole byte write
         always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
               regs_q[gi] <= osd_geom_pkg::REG_RESET;
            end else if (i_ce && i_wr && sel[gi]) begin
               regs_q[gi] <= i_wdata;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------

   // Selected register value; unmapped addresses read as zero.
   logic [7:0] rd_mux;
   // RULE15: readback of written value
   always_comb begin
      rd_mux = osd_geom_pkg::RDATA_IDLE;
      for (int k = 0; k < osd_geom_pkg::NUM_REGS; k++) begin
         if (sel[k]) begin
            rd_mux = regs_q[k];
         end
      end
   end

   // Read data stands only in the cycle after the read strobe.
   // Clearing it outside read cycles keeps a stale byte from being taken for a fresh
   // answer by a master that samples one cycle late.
   logic [7:0] rdata_q;
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         rdata_q <= osd_geom_pkg::RDATA_IDLE;
      end else if (i_ce) begin
         rdata_q <= i_rd ? rd_mux : osd_geom_pkg::RDATA_IDLE;
      end
   end

   // ----------------------------------------------------------------
   // Field extraction
   // ----------------------------------------------------------------

   // Named fields of the stored registers.
   wire logic vsync_invert;
   wire logic hsync_invert;
   wire logic [5:0] vertical_line_offset;
   wire logic [1:0] quarter_char_offset;
   wire logic [5:0] text_left_edge;
   wire logic [5:0] text_right_edge;
   assign vsync_invert = regs_q[osd_geom_pkg::IDX_TVP][osd_geom_pkg::VSYNC_INVERT_BIT];
   assign hsync_invert = regs_q[osd_geom_pkg::IDX_TVP][osd_geom_pkg::HSYNC_INVERT_BIT];
   assign vertical_line_offset =
      regs_q[osd_geom_pkg::IDX_TVP][osd_geom_pkg::VOFS_MSB:osd_geom_pkg::VOFS_LSB];
   assign quarter_char_offset =
      regs_q[osd_geom_pkg::IDX_THP][osd_geom_pkg::QOFS_MSB:osd_geom_pkg::QOFS_LSB];
   assign text_left_edge =
      regs_q[osd_geom_pkg::IDX_THP][osd_geom_pkg::LEFT_MSB:osd_geom_pkg::LEFT_LSB];
   // RULE9: reserved end bits unused
   assign text_right_edge =
      regs_q[osd_geom_pkg::IDX_TAE][osd_geom_pkg::RIGHT_MSB:osd_geom_pkg::RIGHT_LSB];

   // Fringe and scroll fields leave the block straight from the register flops.
   // RULE6: fringe colour select
   assign o_fringe_colour =
      regs_q[osd_geom_pkg::IDX_FRC][osd_geom_pkg::FCOL_MSB:osd_geom_pkg::FCOL_LSB];
   // RULE7: per direction enables
   assign o_fringe_north = regs_q[osd_geom_pkg::IDX_FRC][osd_geom_pkg::FN_BIT];
   assign o_fringe_east = regs_q[osd_geom_pkg::IDX_FRC][osd_geom_pkg::FE_BIT];
   assign o_fringe_south = regs_q[osd_geom_pkg::IDX_FRC][osd_geom_pkg::FS_BIT];
   assign o_fringe_west = regs_q[osd_geom_pkg::IDX_FRC][osd_geom_pkg::FW_BIT];
   // RULE10: scroll area height
   assign o_scroll_window_height =
      regs_q[osd_geom_pkg::IDX_SSA][osd_geom_pkg::SH_MSB:osd_geom_pkg::SH_LSB];
   // RULE11: scroll area top row
   assign o_scroll_window_top_row =
      regs_q[osd_geom_pkg::IDX_SSA][osd_geom_pkg::ST_MSB:osd_geom_pkg::ST_LSB];

   // ----------------------------------------------------------------
   // Sync polarity
   // ----------------------------------------------------------------

   // Syncs as used inside the unit, after optional inversion.
   wire logic vs_now;
   wire logic hs_now;
   // RULE1: vertical sync inversion
   assign vs_now = i_vsync ^ vsync_invert;
   // RULE2: horizontal sync inversion
   assign hs_now = i_hsync ^ hsync_invert;

   logic vsync_q;
   logic hsync_q;
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         vsync_q <= 1'b0;
         hsync_q <= 1'b0;
      end else if (i_ce) begin
         vsync_q <= vs_now;
         hsync_q <= hs_now;
      end
   end

   // The edge detector works on the corrected sync, so flipping a polarity bit while the
   // sync input sits still can itself look like an edge; software should change the
   // polarity bits only while the display is blanked.
   // Rising edges of the corrected syncs, against the previous sample.
   wire logic vs_rise;
   wire logic hs_rise;
   assign vs_rise = vs_now & ~vsync_q;
   assign hs_rise = hs_now & ~hsync_q;

   // ----------------------------------------------------------------
   // Vertical offset of the text area
   // ----------------------------------------------------------------

   osd_geom_pkg::vert_state_e vstate_q;
   osd_geom_pkg::vert_state_e vstate_d;
   logic [5:0] line_cnt_q;
   logic [5:0] line_cnt_d;
   logic text_top_q;
   // Registered copy of the text-row state, so that the output leaves a flop directly.
   logic rows_active_q;

   // Next line count after this horizontal sync.
   wire logic [5:0] line_cnt_inc;
   assign line_cnt_inc = line_cnt_q + osd_geom_pkg::LINE_CNT_STEP;

   // Each vertical sync restarts the count; text rows begin once the offset is reached.
   // An offset lowered while counting still ends the count, because the compare is a
   // greater-or-equal; a raised offset simply waits for more lines.
   // RULE3: vertical line offset
   always_comb begin
      vstate_d = vstate_q;
      line_cnt_d = line_cnt_q;
      if (vs_rise) begin
         line_cnt_d = osd_geom_pkg::LINE_CNT_ZERO;
         if (vertical_line_offset == osd_geom_pkg::LINE_CNT_ZERO) begin
            vstate_d = osd_geom_pkg::V_TEXT;
         end else begin
            vstate_d = osd_geom_pkg::V_COUNT;
         end
      end else begin
         case (vstate_q)
            osd_geom_pkg::V_WAIT: begin
               vstate_d = osd_geom_pkg::V_WAIT;
            end
            osd_geom_pkg::V_COUNT: begin
               if (hs_rise) begin
                  line_cnt_d = line_cnt_inc;
                  if (line_cnt_inc >= vertical_line_offset) begin
                     vstate_d = osd_geom_pkg::V_TEXT;
                  end
               end
            end
            osd_geom_pkg::V_TEXT: begin
               vstate_d = osd_geom_pkg::V_TEXT;
            end
            default: begin
               vstate_d = osd_geom_pkg::V_WAIT;
               line_cnt_d = osd_geom_pkg::LINE_CNT_ZERO;
            end
         endcase
      end
   end

   // The top pulse marks the first cycle of the text rows of a field.
   wire logic entering_text;
   assign entering_text = (vstate_d == osd_geom_pkg::V_TEXT) &&
                          ((vstate_q != osd_geom_pkg::V_TEXT) || vs_rise);

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         vstate_q <= osd_geom_pkg::V_WAIT;
         line_cnt_q <= osd_geom_pkg::LINE_CNT_ZERO;
         text_top_q <= 1'b0;
         rows_active_q <= 1'b0;
      end else if (i_ce) begin
         vstate_q <= vstate_d;
         line_cnt_q <= line_cnt_d;
         text_top_q <= entering_text;
         rows_active_q <= (vstate_d == osd_geom_pkg::V_TEXT);
      end
   end

   // ----------------------------------------------------------------
   // Horizontal extent of the text area
   // ----------------------------------------------------------------

   // Left edge in quarter characters: whole characters then the fine offset.
   wire logic [7:0] start_quarters;
   // RULE5: left edge in characters
   // RULE4: fine quarter shift
   assign start_quarters = {text_left_edge, quarter_char_offset};

   // Right edge: end code plus one characters, shifted by the same fine offset.
   // Seven bits hold the biased end, since the highest code means sixty-four characters.
   wire logic [6:0] end_chars;
   wire logic [8:0] end_quarters;
   // RULE13: end code plus one
   assign end_chars = {1'b0, text_right_edge} + osd_geom_pkg::END_CODE_BIAS;
   // RULE14: fine shift on end
   assign end_quarters = {end_chars, quarter_char_offset};

   // Width in full characters, checked against the usable range.
   // The subtraction wraps when the start passes the end; the first term of width_ok
   // catches that case before the range check can be fooled by the wrapped value.
   wire logic [6:0] width_chars;
   wire logic width_ok;
   // RULE8: width is end minus start
   assign width_chars = end_chars - {1'b0, text_left_edge};
   // RULE13: width limit check
   assign width_ok = (end_chars >= {1'b0, text_left_edge}) &&
                     (width_chars <= osd_geom_pkg::MAX_WIDTH_CHARS);

   // Start codes below four give a corrupted offset; flagged for software.
   // Such codes are not blocked: the geometry is still produced and only flagged.
   wire logic start_bad;
   // RULE12: low start codes flagged
   assign start_bad = (text_left_edge < osd_geom_pkg::MIN_SAFE_START);

   // Pixel position inside the text area on a text row.
   // A width outside the usable range blanks the whole row rather than a clipped part.
   wire logic in_area;
   assign in_area = (vstate_q == osd_geom_pkg::V_TEXT) && width_ok &&
                    ({1'b0, i_hpos_quarters} >= {2'b00, start_quarters}) &&
                    ({1'b0, i_hpos_quarters} < {1'b0, end_quarters});

   logic [7:0] start_q;
   logic [8:0] end_q;
   logic [6:0] width_q;
   logic width_ok_q;
   logic start_bad_q;
   logic in_area_q;
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         start_q <= 8'h00;
         end_q <= 9'h000;
         width_q <= 7'h00;
         width_ok_q <= 1'b0;
         start_bad_q <= 1'b0;
         in_area_q <= 1'b0;
      end else if (i_ce) begin
         start_q <= start_quarters;
         end_q <= end_quarters;
         width_q <= width_ok ? width_chars : 7'h00;
         width_ok_q <= width_ok;
         start_bad_q <= start_bad;
         in_area_q <= in_area;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   // All outputs come straight from flip-flops.
   assign o_rdata = rdata_q;
   assign o_vsync = vsync_q;
   assign o_hsync = hsync_q;
   assign o_text_rows_active = rows_active_q;
   assign o_text_top = text_top_q;
   assign o_in_text_area = in_area_q;
   assign o_text_start_quarters = start_q;
   assign o_text_end_quarters = end_q;
   assign o_text_width_chars = width_q;
   assign o_width_valid = width_ok_q;
   assign o_start_code_bad = start_bad_q;

endmodule

// ---- tb/osd_geom_chk.sv ----
// Purpose: Concurrent checks on the OSD geometry register block ports.
// Assumes: One clock, asynchronous active-high reset, registers clear to zero.
// Notes: Shadow copies of three registers are rebuilt from the bus writes.

`timescale 1ns/100ps

module osd_geom_chk (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_vsync,
   input wire logic i_hsync,
   input wire logic [7:0] o_rdata,
   input wire logic o_vsync,
   input wire logic o_hsync,
   input wire logic o_text_rows_active,
   input wire logic o_text_top,
   input wire logic [7:0] o_text_start_quarters,
   input wire logic [8:0] o_text_end_quarters,
   input wire logic [6:0] o_text_width_chars,
   input wire logic o_width_valid,
   input wire logic [3:0] o_fringe_colour,
   input wire logic o_fringe_north,
   input wire logic o_fringe_east,
   input wire logic o_fringe_south,
   input wire logic o_fringe_west,
   input wire logic [3:0] o_scroll_window_height,
   input wire logic [3:0] o_scroll_window_top_row
);
   // -------------------------------------------------------------
   // Shadow registers and expected geometry
   // -------------------------------------------------------------
   logic [7:0] tvp_q;
   logic [7:0] thp_q;
   logic [7:0] tae_q;
   wire logic wr_hit = i_ce && i_wr;
   wire logic [6:0] end_chars = {1'b0, tae_q[5:0]} + 7'h01;
   wire logic [7:0] span = {1'b0, end_chars} - {2'b00, thp_q[5:0]};
   wire logic span_ok = !span[7] && (span[6:0] <= 7'h30);
   wire logic [7:0] geo_start = {thp_q[5:0], thp_q[7:6]};
   wire logic [8:0] geo_end = {end_chars, thp_q[7:6]};
   wire logic [7:0] geo_width = {span_ok, span_ok ? span[6:0] : 7'h00};

   // Mirrors the stored bytes so that derived outputs can be predicted.
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         tvp_q <= 8'h00;
         thp_q <= 8'h00;
         tae_q <= 8'h00;
      end else if (wr_hit) begin
         if (i_addr == 16'h87F1) tvp_q <= i_wdata;
         if (i_addr == 16'h87F2) thp_q <= i_wdata;
         if (i_addr == 16'h87F4) tae_q <= i_wdata;
      end
   end

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);

   AST_VSYNC_POL: assert property (i_ce |=> o_vsync == $past(i_vsync ^ tvp_q[7]))
      else $error("vsync output ignores its polarity bit");
   AST_HSYNC_POL: assert property (i_ce |=> o_hsync == $past(i_hsync ^ tvp_q[6]))
      else $error("hsync output ignores its polarity bit");
   AST_TOP_PULSE: assert property ((i_ce && o_text_top) |-> o_text_rows_active ##1 !o_text_top)
      else $error("text top pulse malformed");
   AST_START_POS: assert property (i_ce |=> o_text_start_quarters == $past(geo_start))
      else $error("text start position wrong");
   AST_END_POS: assert property (i_ce |=> o_text_end_quarters == $past(geo_end))
      else $error("text end position wrong");
   AST_WIDTH: assert property (i_ce |=> {o_width_valid, o_text_width_chars} == $past(geo_width))
      else $error("text width or validity wrong");
   AST_FRINGE: assert property ((wr_hit && i_addr == 16'h87F3) |=>
      {o_fringe_colour, o_fringe_north, o_fringe_east, o_fringe_south, o_fringe_west}
      == $past(i_wdata)) else $error("fringe fields do not follow write");
   AST_SCROLL: assert property ((wr_hit && i_addr == 16'h87F5) |=>
      {o_scroll_window_height, o_scroll_window_top_row} == $past(i_wdata))
      else $error("scroll fields do not follow write");
   AST_READBACK: assert property ((wr_hit && i_addr >= 16'h87F1 && i_addr <= 16'h87F5)
      ##1 (i_ce && i_rd && i_addr == $past(i_addr)) |=> o_rdata == $past(i_wdata, 2))
      else $error("read after write returns wrong byte");
   AST_RD_IDLE: assert property ((i_ce && !i_rd) |=> o_rdata == 8'h00)
      else $error("read data not idle outside a read");
endmodule

bind osd_text_area_geometry_regs osd_geom_chk osd_geom_chk_i (.i_clk, .i_reset, .i_ce, .i_addr,
   .i_wdata, .i_wr, .i_rd, .i_vsync, .i_hsync, .o_rdata, .o_vsync, .o_hsync, .o_text_rows_active,
   .o_text_top, .o_text_start_quarters, .o_text_end_quarters, .o_text_width_chars, .o_width_valid,
   .o_fringe_colour, .o_fringe_north, .o_fringe_east, .o_fringe_south, .o_fringe_west,
   .o_scroll_window_height, .o_scroll_window_top_row);

// ---- tb/osd_text_area_geometry_regs_tb.sv ----
// Purpose: Self-checking bench for the OSD geometry register block.
// Assumes: Registers clear to zero; read data stands one cycle after the strobe.
// Notes: A byte model of the five registers predicts every result.

`timescale 1ns/100ps

module osd_text_area_geometry_regs_tb;
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_ce = 1'b1;
   logic [15:0] i_addr = 16'h0000;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_vsync = 1'b0;
   logic i_hsync = 1'b0;
   logic [8:0] i_hpos_quarters = 9'h000;
   logic [7:0] o_rdata, o_text_start_quarters;
   logic [8:0] o_text_end_quarters;
   logic [6:0] o_text_width_chars;
   logic [3:0] o_fringe_colour, o_scroll_window_height, o_scroll_window_top_row;
   logic o_vsync, o_hsync, o_text_rows_active, o_text_top, o_in_text_area, o_width_valid;
   logic o_start_code_bad, o_fringe_north, o_fringe_east, o_fringe_south, o_fringe_west;
   int fail_count = 0;
   int checks = 0;
   integer seed = 32'h8497621F;
   logic [7:0] mdl [5];
   logic [7:0] hv [7] = '{8'h04, 8'h04, 8'h0A, 8'h0A, 8'h03, 8'hD0, 8'hFF};
   logic [7:0] ev [7] = '{8'h33, 8'h34, 8'h08, 8'h09, 8'h00, 8'hFF, 8'h3F};
   int s, e, w;
   logic ok;
   logic [15:0] a;
   logic [8:0] h;

   osd_text_area_geometry_regs osd_text_area_geometry_regs_i (.i_clk, .i_reset, .i_ce, .i_addr,
      .i_wdata, .i_wr, .i_rd, .i_vsync, .i_hsync, .i_hpos_quarters, .o_rdata, .o_vsync, .o_hsync,
      .o_text_rows_active, .o_text_top, .o_in_text_area, .o_text_start_quarters,
      .o_text_end_quarters, .o_text_width_chars, .o_width_valid, .o_start_code_bad,
      .o_fringe_colour, .o_fringe_north, .o_fringe_east, .o_fringe_south, .o_fringe_west,
      .o_scroll_window_height, .o_scroll_window_top_row);

   // Free-running 125 MHz clock.
   always #4 i_clk = ~i_clk;

   // -------------------------------------------------------------
   // Bus, model and comparison tasks
   // -------------------------------------------------------------
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // A set more keeps the strobe up for a write that follows at once.
   task automatic wr(input logic [15:0] ad, input logic [7:0] d, input logic more);
      i_wr <= 1'b1;
      i_addr <= ad;
      i_wdata <= d;
      @(posedge i_clk);
      if (!more) i_wr <= 1'b0;
      if (i_ce && ad >= 16'h87F1 && ad <= 16'h87F5) mdl[ad - 16'h87F1] = d;
   endtask

   task automatic rd(input logic [15:0] ad);
      logic [7:0] x;
      x = (ad >= 16'h87F1 && ad <= 16'h87F5) ? mdl[ad - 16'h87F1] : 8'h00;
      i_rd <= 1'b1;
      i_addr <= ad;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(negedge i_clk);
      chk(9'(o_rdata), 9'(x));
      @(negedge i_clk);
      chk(9'(o_rdata), 9'h000);
      @(posedge i_clk);
   endtask

   task automatic geo;
      s = mdl[1][5:0] * 4 + mdl[1][7:6];
      e = (mdl[3][5:0] + 1) * 4 + mdl[1][7:6];
      w = mdl[3][5:0] + 1 - mdl[1][5:0];
      ok = w >= 0 && w <= 48;
   endtask

   task automatic fields;
      geo();
      @(negedge i_clk);
      chk(9'({o_fringe_colour, o_fringe_north, o_fringe_east, o_fringe_south, o_fringe_west}),
         9'(mdl[2]));
      chk(9'({o_scroll_window_height, o_scroll_window_top_row}), 9'(mdl[4]));
      @(negedge i_clk);
      chk(9'(o_text_start_quarters), 9'(s));
      chk(o_text_end_quarters, 9'(e));
      chk(9'({o_width_valid, o_text_width_chars}), 9'(ok ? 128 + w : 0));
      chk(9'(o_start_code_bad), 9'(mdl[1][5:0] < 4));
      @(posedge i_clk);
   endtask

   task automatic frame(input int off, input logic vi, input logic hi);
      int n;
      wr(16'h87F1, {vi, hi, 6'(off)}, 1'b0);
      i_vsync <= vi;
      i_hsync <= hi;
      repeat (3) @(posedge i_clk);
      i_vsync <= ~vi;
      repeat (2) @(posedge i_clk);
      i_vsync <= vi;
      repeat (3) @(posedge i_clk);
      n = 0;
      @(negedge i_clk);
      while (n < 70 && o_text_rows_active !== 1'b1) begin
         @(posedge i_clk);
         i_hsync <= ~hi;
         @(posedge i_clk);
         i_hsync <= hi;
         @(negedge i_clk);
         chk(9'(o_text_top), 9'(n + 1 == off));
         repeat (2) @(negedge i_clk);
         n++;
      end
      chk(9'(n), 9'(off));
   endtask

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Cuts a hung run short.
   initial begin
      repeat (20000) @(posedge i_clk);
      fail_count++;
      tally_and_finish();
   end

   // Main test sequence.
   initial begin
      for (int k = 0; k < 5; k++) mdl[k] = osd_geom_pkg::REG_RESET;
      repeat (12) @(posedge i_clk);
      i_reset <= 1'b0;
      @(posedge i_clk);
      for (int k = 0; k < 7; k++) rd(16'h87F0 + 16'(k));
      fields();
      $display("Reset values test done");
      repeat (40) begin
         a = 16'h87F0 + 16'($unsigned($random(seed)) % 7);
         wr(a, 8'($random(seed)), 1'b0);
         rd(a);
         fields();
      end
      $display("Random access test done");
      for (int k = 0; k < 7; k++) begin
         wr(16'h87F2, hv[k], 1'b1);
         wr(16'h87F4, ev[k], 1'b0);
         fields();
      end
      rd(16'h87F4);
      $display("Geometry boundary test done");
      i_ce <= 1'b0;
      wr(16'h87F3, ~mdl[2], 1'b0);
      i_ce <= 1'b1;
      rd(16'h87F3);
      fields();
      $display("Clock enable test done");
      for (int k = 0; k < 5; k++) begin
         wr(16'h87F2, 8'($random(seed)) | 8'h04, 1'b1);
         wr(16'h87F4, 8'($random(seed)), 1'b1);
         frame(k == 4 ? 63 : k * 2, k[0], k[1]);
         geo();
         repeat (12) begin
            h = 9'($unsigned($random(seed)) % 300);
            @(posedge i_clk);
            i_hpos_quarters <= h;
            @(posedge i_clk);
            @(negedge i_clk);
            chk(9'(o_in_text_area), 9'(ok && h >= s && h < e));
         end
         @(posedge i_clk);
      end
      $display("Frame and text area test done");
      tally_and_finish();
   end
endmodule
